// ### dv/fsc_flash_model.sv
// Purpose: behavioural flash device on the far side of the host
// Assumes: strobes framed by the host; no clock reaches the pins
// Notes: logs every write; reads return a word derived from the address
`timescale 1ns/100ps
module fsc_flash_model
(
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  output logic      [15:0] dq_in
);
  fsc_pkg::fsc_cyc_t log_q[$];
  logic [21:0]       adr_lat;
  logic              act = 1'b0;
  logic              pgm = 1'b0;
  logic              ers = 1'b0;
  logic              susp = 1'b0;
  logic              idm = 1'b0;
  logic [9:0]        esec = 10'h000;
  // Address on the later falling strobe
  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n)
    begin
      adr_lat = addr;
      act = 1'b1;
    end
  // Data on the first rising strobe; flag stops a double log
  always @(posedge we_n or posedge ce_n)
    if (act)
    begin
      log_q.push_back({adr_lat, dq_out});
      act = 1'b0;
      // Low data byte alone picks the action; the payload after A0 is skipped
      if (pgm)
        pgm = 1'b0;
      else
        case (dq_out[7:0])
          8'hA0: pgm = 1'b1;
          8'h30:
          begin
            if (!susp)
              esec = adr_lat[21:12];
            ers  = 1'b1;
            susp = 1'b0;
          end
          8'hB0: susp = ers;
          8'h10: ers = 1'b0;
          8'h90: idm = 1'b1;
          8'h00, 8'hF0: idm = 1'b0;
          default: if (!susp) ers = 1'b0;
        endcase
    end
  // Released bus flips, so a stale value is never mistaken for data
  always @(oe_n or ce_n or addr)
    if (ce_n || oe_n)
      dq_in = ~dq_in;
    else if (idm)
      dq_in = (addr[1:0] == 2'h3) ? 16'h0019 : 16'h0000;
    else if (susp && addr[21:12] == esec)
      dq_in = 16'h0080;
    else
      dq_in = {addr[7:0] ^ 8'hC3, addr[15:8]};
endmodule

// ### dv/testbench.sv
// Purpose: self-checking bench for the flash command sequencer host
// Assumes: short suspend and window counts of 8 cycles
// Notes: pin writes are compared against sequences built here
`timescale 1ns/100ps
module testbench;
  logic        MCLK = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdat;
  logic        ce_n, we_n, oe_n, dq_oe;
  logic [21:0] fa;
  logic [15:0] dqo, dqi;
  logic [31:0] rnd = 32'h0B729135;
  logic [31:0] s;
  logic [21:0] pa;
  logic [21:0] qa;
  logic [15:0] pd;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  fsc_host #(.SUSP_CYC(8), .WIN_CYC(8)) u_fsc_host (.MCLK(MCLK), .RSTN(rstn),
    .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdat),
    .FLASH_CE_N(ce_n), .FLASH_WE_N(we_n), .FLASH_OE_N(oe_n), .FLASH_ADDR(fa),
    .FLASH_DQ_OUT(dqo), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_IN(dqi));
  fsc_flash_model u_fsc_flash_model (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .addr(fa), .dq_out(dqo), .dq_oe(dq_oe), .dq_in(dqi));
  // 25 MHz clock
  always #20 MCLK = ~MCLK;
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [21:0] first(input logic b);
    return b ? fsc_pkg::ADR_B_FIRST : fsc_pkg::ADR_W_FIRST;
  endfunction
  task automatic final_report();
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle strobes with an idle cycle between, so no double drive
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge MCLK);
    wr_s <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge MCLK);
    rd_s <= 1'b0;
    @(negedge MCLK);
    d = rdat;
    @(posedge MCLK);
  endtask
  task automatic op(input logic [3:0] c, input logic b, input logic [21:0] a,
                    input logic [15:0] d);
    wr(fsc_pkg::REG_ADDR, {10'h0, a});
    wr(fsc_pkg::REG_DATA, {16'h0, d});
    wr(fsc_pkg::REG_CTRL, {23'h0, b, 4'h0, c});
    repeat (2) @(posedge MCLK);
    s = 32'h1;
    for (int i = 0; i < 200 && s[0] !== 1'b0; i++)
      rd(fsc_pkg::REG_STATUS, s);
  endtask
  // Pops one logged write; don't-care address and upper byte masked
  task automatic expw(input logic [21:0] a, input logic [7:0] d, input logic anya);
    fsc_pkg::fsc_cyc_t g;
    g = '0;
    if (u_fsc_flash_model.log_q.size() > 0)
      g = u_fsc_flash_model.log_q.pop_front();
    if (anya)
      g.addr = a;
    check(64'(g) & 64'hFFFFFFFF00FF, 64'({a, 8'h00, d}));
  endtask
  task automatic unl(input logic b);
    expw(first(b), fsc_pkg::CMD_UNLOCK1, 1'b0);
    expw(b ? fsc_pkg::ADR_B_SECOND : fsc_pkg::ADR_W_SECOND, 8'h55, 1'b0);
  endtask
  initial
  begin
    repeat (16) @(posedge MCLK);
    rstn <= 1'b1;
    @(posedge MCLK);
    // Suspend with no sector erase pending never reaches the pins
    op(4'h9, 1'b0, 22'h0, 16'h0);
    check(64'(u_fsc_flash_model.log_q.size()), 64'h0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      pa = rnd[21:0];
      pd = rnd[31:16];
      op(4'h3, i[0], pa, pd);
      unl(i[0]);
      expw(first(i[0]), fsc_pkg::CMD_PROGRAM, 1'b0);
      check(64'(u_fsc_flash_model.log_q.pop_front()), 64'({pa, pd}));
    end
    op(4'h8, 1'b0, {pa[21:12], 12'h000}, 16'h0);
    unl(1'b0);
    expw(fsc_pkg::ADR_W_FIRST, fsc_pkg::CMD_ERASE_SET, 1'b0);
    unl(1'b0);
    expw({pa[21:12], 12'h000}, fsc_pkg::CMD_SECTOR, 1'b0);
    op(4'h9, 1'b0, 22'h0, 16'h0);
    expw(22'h0, fsc_pkg::CMD_SUSPEND, 1'b1);
    rd(fsc_pkg::REG_STATUS, s);
    check(64'(s[1]), 64'h1);
    rnd = lfsr(rnd);
    qa = {~pa[21:12], rnd[11:0]};
    op(4'h2, 1'b0, qa, 16'h0);
    rd(fsc_pkg::REG_RDATA, s);
    check(64'(s[15:0]), 64'({qa[7:0] ^ 8'hC3, qa[15:8]}));
    op(4'h2, 1'b0, {pa[21:12], 12'h003}, 16'h0);
    rd(fsc_pkg::REG_RDATA, s);
    check(64'(s[15:0]), 64'h0080);
    op(4'h1, 1'b0, 22'h3, 16'h0);
    unl(1'b0);
    expw(fsc_pkg::ADR_W_FIRST, fsc_pkg::CMD_IDENT, 1'b0);
    op(4'h2, 1'b0, 22'h3, 16'h0);
    rd(fsc_pkg::REG_RDATA, s);
    check(64'(s[15:0]), 64'h0019);
    op(4'h0, 1'b0, 22'h0, 16'h0);
    expw(22'h0, fsc_pkg::CMD_RESET, 1'b1);
    op(4'h3, 1'b0, qa, rnd[31:16]);
    unl(1'b0);
    expw(fsc_pkg::ADR_W_FIRST, fsc_pkg::CMD_PROGRAM, 1'b0);
    check(64'(u_fsc_flash_model.log_q.pop_front()), 64'({qa, rnd[31:16]}));
    rd(fsc_pkg::REG_STATUS, s);
    check(64'(s[3:1]), 64'h1);
    op(4'hA, 1'b0, 22'h0, 16'h0);
    expw(22'h0, fsc_pkg::CMD_RESUME, 1'b1);
    rd(fsc_pkg::REG_STATUS, s);
    check(64'(s[1]), 64'h0);
    op(4'h4, 1'b0, 22'h0, 16'h0);
    unl(1'b0);
    expw(fsc_pkg::ADR_W_FIRST, fsc_pkg::CMD_BYPASS, 1'b0);
    op(4'h5, 1'b0, pa, pd);
    expw(22'h0, fsc_pkg::CMD_PROGRAM, 1'b1);
    check(64'(u_fsc_flash_model.log_q.pop_front()), 64'({pa, pd}));
    op(4'h6, 1'b0, 22'h0, 16'h0);
    expw(22'h0, fsc_pkg::CMD_IDENT, 1'b1);
    expw(22'h0, fsc_pkg::CMD_ZERO, 1'b1);
    op(4'hB, 1'b1, 22'h0, 16'h0);
    expw(fsc_pkg::ADR_B_QUERY, fsc_pkg::CMD_QUERY, 1'b0);
    op(4'h0, 1'b0, 22'h0, 16'h0);
    expw(22'h0, fsc_pkg::CMD_RESET, 1'b1);
    op(4'h7, 1'b0, 22'h0, 16'h0);
    unl(1'b0);
    expw(fsc_pkg::ADR_W_FIRST, fsc_pkg::CMD_ERASE_SET, 1'b0);
    unl(1'b0);
    expw(fsc_pkg::ADR_W_FIRST, fsc_pkg::CMD_CHIP, 1'b0);
    op(4'h9, 1'b0, 22'h0, 16'h0);
    check(64'(u_fsc_flash_model.log_q.size()), 64'h0);
    final_report();
  end
endmodule

// ### src/fsc_bus_cycle.sv
// Purpose: one write or read cycle on the flash pins
// Assumes: chip select and write strobe fall and rise together
// Notes: address stands before the falling strobe, data held past rise
`timescale 1ns/100ps
module fsc_bus_cycle
#(
  parameter int WP_CYC = fsc_pkg::T_WP_CYC
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             is_write,
  input  wire fsc_pkg::fsc_cyc_t cyc,
  input  wire logic [15:0]      dq_in,
  output logic                  done,
  output logic [15:0]           rdata,
  output logic                  ce_n,
  output logic                  we_n,
  output logic                  oe_n,
  output logic [21:0]           addr,
  output logic [15:0]           dq_out,
  output logic                  dq_oe
);

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} fsc_bc_t;
  fsc_bc_t     st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d;
  logic [21:0] addr_q, addr_d;
  logic [15:0] dat_q, dat_d;
  logic [15:0] rd_q, rd_d;

  // Next state; address settles a full cycle before the strobe falls
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    wr_d   = wr_q;
    addr_d = addr_q;
    dat_d  = dat_q;
    rd_d   = rd_q;
    unique case (st_q)
      S_IDLE:
      begin
        if (start)
        begin
          st_d   = S_SETUP;
          wr_d   = is_write;
          addr_d = cyc.addr;
          dat_d  = cyc.data;
        end
      end
      S_SETUP:
      begin
        st_d  = S_STROBE;
        cnt_d = 8'(WP_CYC);
      end
      S_STROBE:
      begin
        if (cnt_q <= 8'h01)
        begin
          st_d = S_HOLD;
          if (!wr_q)
            rd_d = dq_in;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      S_HOLD:
        st_d = S_IDLE; // Data held one cycle past the rising strobe
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q   <= S_IDLE;
      cnt_q  <= 8'h00;
      wr_q   <= 1'b0;
      addr_q <= 22'h000000;
      dat_q  <= 16'h0000;
      rd_q   <= 16'h0000;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      wr_q   <= wr_d;
      addr_q <= addr_d;
      dat_q  <= dat_d;
      rd_q   <= rd_d;
    end
  end

  // Pin drive; both strobes move together so latch edges coincide
  assign ce_n   = (st_q != S_STROBE);
  assign we_n   = !((st_q == S_STROBE) && wr_q);
  assign oe_n   = !((st_q == S_STROBE) && !wr_q);
  assign addr   = addr_q;
  assign dq_out = dat_q;
  assign dq_oe  = wr_q && (st_q != S_IDLE);
  assign done   = (st_q == S_HOLD);
  assign rdata  = rd_q;

  chk_data_held: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(we_n) |-> dq_oe && $stable(dq_out))
    else $error("write data not held at strobe rise");
  chk_addr_setup: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(ce_n) |-> $stable(addr))
    else $error("address moved at strobe fall");

endmodule

// ### src/fsc_host.sv
// Purpose: host controller issuing flash command sequences
// Assumes: software writes ADDR and DATA before an op in CTRL
// Notes: tracks suspend, bypass and identification modes for status
`timescale 1ns/100ps
module fsc_host
#(
  parameter int SUSP_CYC = fsc_pkg::T_SUSP_CYC,
  parameter int WIN_CYC  = fsc_pkg::T_WIN_CYC
)
(
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA,
  output logic             FLASH_CE_N,
  output logic             FLASH_WE_N,
  output logic             FLASH_OE_N,
  output logic [21:0]      FLASH_ADDR,
  output logic [15:0]      FLASH_DQ_OUT,
  output logic             FLASH_DQ_OE,
  input  wire logic [15:0] FLASH_DQ_IN
);

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [21:0] tgt_q, tgt_d;
  logic [15:0] pay_q, pay_d;
  logic        byte_q, byte_d;
  logic [31:0] rdat_q, rdat_d;

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT, H_HOLD} fsc_hs_t;
  fsc_hs_t              st_q, st_d;
  fsc_pkg::fsc_op_t     op_q, op_d;
  logic [2:0]           idx_q, idx_d;
  logic [15:0]          hold_q, hold_d;
  logic                 susp_q, susp_d;
  logic                 sect_q, sect_d;
  logic                 chip_q, chip_d;
  logic                 byp_q, byp_d;
  logic                 ident_q, ident_d;
  logic [15:0]          lastrd_q, lastrd_d;

  logic                 bc_start;
  logic                 bc_write;
  logic                 bc_done;
  logic [15:0]          bc_rdata;
  fsc_pkg::fsc_cyc_t    bc_cyc;
  logic [2:0]           n_cyc;
  logic                 accept;
  fsc_pkg::fsc_op_t     req_op;

  // Unlock address of step k, byte or word layout
  function automatic logic [21:0] unl_addr(input logic second, input logic bmode);
    if (bmode)
      unl_addr = second ? fsc_pkg::ADR_B_SECOND : fsc_pkg::ADR_B_FIRST;
    else
      unl_addr = second ? fsc_pkg::ADR_W_SECOND : fsc_pkg::ADR_W_FIRST;
  endfunction

  function automatic fsc_pkg::fsc_cyc_t mk(input logic [21:0] a, input logic [7:0] d);
    mk.addr = a;
    mk.data = {8'h00, d};
  endfunction

  // Cycle count per operation
  always_comb
  begin
    unique case (op_q)
      fsc_pkg::OP_RESET, fsc_pkg::OP_SUSPEND, fsc_pkg::OP_RESUME,
      fsc_pkg::OP_QUERY, fsc_pkg::OP_READ, fsc_pkg::OP_SECT_MORE: n_cyc = 3'd1;
      fsc_pkg::OP_BYP_PROG, fsc_pkg::OP_BYP_EXIT:                 n_cyc = 3'd2;
      fsc_pkg::OP_IDENT, fsc_pkg::OP_BYP_ENTER,
      fsc_pkg::OP_SEC_ENTER:                                      n_cyc = 3'd3;
      fsc_pkg::OP_PROGRAM, fsc_pkg::OP_SEC_EXIT:                  n_cyc = 3'd4;
      default:                                                    n_cyc = 3'd6;
    endcase
  end

  // Address and data of bus cycle idx for the running op
  always_comb
  begin
    bc_write = (op_q != fsc_pkg::OP_READ);
    bc_cyc   = mk(unl_addr(idx_q[0], byte_q), (idx_q[0] ? fsc_pkg::CMD_UNLOCK2
                                                        : fsc_pkg::CMD_UNLOCK1));
    if ((idx_q == 3'd3 || idx_q == 3'd4) && n_cyc == 3'd6)
      bc_cyc = mk(unl_addr(~idx_q[0], byte_q), (idx_q[0] ? fsc_pkg::CMD_UNLOCK1
                                                         : fsc_pkg::CMD_UNLOCK2));
    unique case (op_q)
      fsc_pkg::OP_RESET:   bc_cyc = mk(tgt_q, fsc_pkg::CMD_RESET);
      fsc_pkg::OP_SUSPEND: bc_cyc = mk(tgt_q, fsc_pkg::CMD_SUSPEND);
      fsc_pkg::OP_RESUME:  bc_cyc = mk(tgt_q, fsc_pkg::CMD_RESUME);
      fsc_pkg::OP_READ:    bc_cyc = mk(tgt_q, 8'h00);
      fsc_pkg::OP_SECT_MORE: bc_cyc = mk(tgt_q, fsc_pkg::CMD_SECTOR);
      fsc_pkg::OP_QUERY:   bc_cyc = mk(byte_q ? fsc_pkg::ADR_B_QUERY
                                              : fsc_pkg::ADR_W_QUERY, fsc_pkg::CMD_QUERY);
      fsc_pkg::OP_BYP_PROG:
        bc_cyc = idx_q == 3'd0 ? mk(tgt_q, fsc_pkg::CMD_PROGRAM)
                               : fsc_pkg::fsc_cyc_t'{addr: tgt_q, data: pay_q};
      fsc_pkg::OP_BYP_EXIT:
        bc_cyc = mk(tgt_q, idx_q == 3'd0 ? fsc_pkg::CMD_IDENT : fsc_pkg::CMD_ZERO);
      fsc_pkg::OP_IDENT:
        if (idx_q == 3'd2) bc_cyc = mk(unl_addr(1'b0, byte_q), fsc_pkg::CMD_IDENT);
      fsc_pkg::OP_BYP_ENTER:
        if (idx_q == 3'd2) bc_cyc = mk(unl_addr(1'b0, byte_q), fsc_pkg::CMD_BYPASS);
      fsc_pkg::OP_SEC_ENTER:
        if (idx_q == 3'd2) bc_cyc = mk(unl_addr(1'b0, byte_q), fsc_pkg::CMD_SECURE);
      fsc_pkg::OP_SEC_EXIT:
      begin
        if (idx_q == 3'd2) bc_cyc = mk(unl_addr(1'b0, byte_q), fsc_pkg::CMD_IDENT);
        if (idx_q == 3'd3) bc_cyc = mk(tgt_q, fsc_pkg::CMD_ZERO);
      end
      fsc_pkg::OP_PROGRAM:
      begin
        if (idx_q == 3'd2) bc_cyc = mk(unl_addr(1'b0, byte_q), fsc_pkg::CMD_PROGRAM);
        if (idx_q == 3'd3) bc_cyc = '{addr: tgt_q, data: pay_q};
      end
      default:
      begin
        if (idx_q == 3'd2) bc_cyc = mk(unl_addr(1'b0, byte_q), fsc_pkg::CMD_ERASE_SET);
        if (idx_q == 3'd5)
          bc_cyc = (op_q == fsc_pkg::OP_CHIP_ERASE)
                 ? mk(unl_addr(1'b0, byte_q), fsc_pkg::CMD_CHIP)
                 : mk({tgt_q[21:12], 12'h000}, fsc_pkg::CMD_SECTOR);
      end
    endcase
  end

  // Software requests refused while busy or in a mode that forbids them
  always_comb
  begin
    req_op = fsc_pkg::fsc_op_t'(REG_WDATA[fsc_pkg::CTRL_OP_LSB +: 4]);
    accept = REG_WR && REG_ADDR == fsc_pkg::REG_CTRL && st_q == H_IDLE;
    unique case (req_op)
      fsc_pkg::OP_SUSPEND:  accept = accept && sect_q && !susp_q;
      fsc_pkg::OP_RESUME:   accept = accept && susp_q;
      fsc_pkg::OP_QUERY:    accept = accept && !susp_q && !byp_q;
      fsc_pkg::OP_BYP_PROG, fsc_pkg::OP_BYP_EXIT: accept = accept && byp_q;
      fsc_pkg::OP_IDENT, fsc_pkg::OP_READ,
      fsc_pkg::OP_PROGRAM:  accept = accept && !byp_q;
      fsc_pkg::OP_SECT_MORE: accept = accept && sect_q && !susp_q && hold_q != 16'h0000;
      default:              accept = accept && !byp_q && !susp_q && !ident_q;
    endcase
    if (req_op == fsc_pkg::OP_RESET)
      accept = REG_WR && REG_ADDR == fsc_pkg::REG_CTRL && st_q == H_IDLE && !byp_q;
  end

  // Main next-state logic
  always_comb
  begin
    st_d = st_q; op_d = op_q; idx_d = idx_q; hold_d = hold_q;
    susp_d = susp_q; sect_d = sect_q; chip_d = chip_q; byp_d = byp_q;
    ident_d = ident_q; lastrd_d = lastrd_q;
    tgt_d = tgt_q; pay_d = pay_q; byte_d = byte_q; rdat_d = 32'h0;
    bc_start = 1'b0;
    if (REG_WR && REG_ADDR == fsc_pkg::REG_ADDR) tgt_d = REG_WDATA[21:0];
    if (REG_WR && REG_ADDR == fsc_pkg::REG_DATA) pay_d = REG_WDATA[15:0];
    if (REG_WR && REG_ADDR == fsc_pkg::REG_CTRL && st_q == H_IDLE)
      byte_d = REG_WDATA[fsc_pkg::CTRL_BYTE_BIT];
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        fsc_pkg::REG_STATUS: rdat_d = {27'h0, chip_q, ident_q, byp_q, susp_q,
                                       st_q != H_IDLE};
        fsc_pkg::REG_RDATA:  rdat_d = {16'h0, lastrd_q};
        fsc_pkg::REG_ADDR:   rdat_d = {10'h0, tgt_q};
        fsc_pkg::REG_DATA:   rdat_d = {16'h0, pay_q};
        default:             rdat_d = 32'h0;
      endcase
    end
    if (hold_q != 16'h0000 && st_q == H_IDLE)
    begin
      hold_d = hold_q - 16'h0001; // Collection window or erase run
      if (hold_q == 16'h0001)
        chip_d = 1'b0;
    end
    unique case (st_q)
      H_IDLE:
        if (accept)
        begin
          st_d  = H_ISSUE;
          op_d  = req_op;
          idx_d = 3'd0;
        end
      H_ISSUE:
      begin
        bc_start = 1'b1;
        st_d     = H_WAIT;
      end
      H_WAIT:
        if (bc_done)
        begin
          if (op_q == fsc_pkg::OP_READ) lastrd_d = bc_rdata;
          if (idx_q + 3'd1 < n_cyc)
          begin
            idx_d = idx_q + 3'd1;
            st_d  = H_ISSUE;
          end
          else
          begin
            st_d = H_IDLE;
            unique case (op_q)
              fsc_pkg::OP_SECT_ERASE, fsc_pkg::OP_SECT_MORE:
              begin
                sect_d = 1'b1;
                hold_d = 16'(WIN_CYC);
              end
              fsc_pkg::OP_CHIP_ERASE:
              begin
                chip_d = 1'b1;
                sect_d = 1'b0; // Chip erase replaces it; no suspend until a new sector erase
                hold_d = 16'(WIN_CYC);
              end
              fsc_pkg::OP_SUSPEND:
              begin
                st_d   = H_HOLD;
                hold_d = 16'(SUSP_CYC);
              end
              fsc_pkg::OP_RESUME:   susp_d = 1'b0;
              fsc_pkg::OP_IDENT:    ident_d = 1'b1;
              fsc_pkg::OP_RESET:    ident_d = 1'b0;
              fsc_pkg::OP_BYP_ENTER: byp_d = 1'b1;
              fsc_pkg::OP_BYP_EXIT: byp_d = 1'b0;
              default:              ;
            endcase
          end
        end
      H_HOLD:
      begin
        // Worst-case halt time before the suspended area may be used
        hold_d = hold_q - 16'h0001;
        if (hold_q <= 16'h0001)
        begin
          st_d   = H_IDLE;
          susp_d = 1'b1;
          hold_d = 16'h0000;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      st_q <= H_IDLE; op_q <= fsc_pkg::OP_RESET; idx_q <= 3'd0; hold_q <= 16'h0000;
      susp_q <= 1'b0; sect_q <= 1'b0; chip_q <= 1'b0; byp_q <= 1'b0;
      ident_q <= 1'b0; lastrd_q <= 16'h0000; tgt_q <= 22'h000000;
      pay_q <= 16'h0000; byte_q <= 1'b0; rdat_q <= 32'h0;
    end
    else
    begin
      st_q <= st_d; op_q <= op_d; idx_q <= idx_d; hold_q <= hold_d;
      susp_q <= susp_d; sect_q <= sect_d; chip_q <= chip_d; byp_q <= byp_d;
      ident_q <= ident_d; lastrd_q <= lastrd_d; tgt_q <= tgt_d;
      pay_q <= pay_d; byte_q <= byte_d; rdat_q <= rdat_d;
    end
  end

  assign REG_RDATA = rdat_q;

  // ****************************************************************
  // Pin cycle engine
  // ****************************************************************
  fsc_bus_cycle u_cyc
  (
    .clk      (MCLK),
    .rst_n    (RSTN),
    .start    (bc_start),
    .is_write (bc_write),
    .cyc      (bc_cyc),
    .dq_in    (FLASH_DQ_IN),
    .done     (bc_done),
    .rdata    (bc_rdata),
    .ce_n     (FLASH_CE_N),
    .we_n     (FLASH_WE_N),
    .oe_n     (FLASH_OE_N),
    .addr     (FLASH_ADDR),
    .dq_out   (FLASH_DQ_OUT),
    .dq_oe    (FLASH_DQ_OE)
  );

  chk_susp_gate: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == H_ISSUE && op_q == fsc_pkg::OP_SUSPEND) |-> sect_q)
    else $error("suspend issued outside sector erase");
  chk_resume_only: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == H_ISSUE && op_q == fsc_pkg::OP_RESUME) |-> susp_q)
    else $error("resume issued while not suspended");
  chk_query_mode: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == H_ISSUE && op_q == fsc_pkg::OP_QUERY) |-> !susp_q && !byp_q)
    else $error("query issued in wrong mode");
  chk_byp_exit: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == H_WAIT && bc_done && op_q == fsc_pkg::OP_BYP_EXIT && idx_q == 3'd1)
    |=> !byp_q)
    else $error("bypass flag not cleared");
  chk_susp_set: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == H_HOLD && hold_q == 16'h0001) |=> susp_q && st_q == H_IDLE)
    else $error("suspend flag late");
  chk_unlock_data: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == H_ISSUE && op_q == fsc_pkg::OP_PROGRAM && idx_q == 3'd0)
    |-> bc_cyc.data == 16'h00AA)
    else $error("first unlock data wrong");
  chk_prog_code: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == H_ISSUE && op_q == fsc_pkg::OP_PROGRAM && idx_q == 3'd2)
    |-> bc_cyc.data == 16'h00A0)
    else $error("program code wrong");
  chk_sect_addr: assert property (@(posedge MCLK) disable iff (!RSTN)
    (st_q == H_ISSUE && op_q == fsc_pkg::OP_SECT_ERASE && idx_q == 3'd5)
    |-> bc_cyc.addr[11:0] == 12'h000 && bc_cyc.data == 16'h0030)
    else $error("sector erase cycle wrong");

endmodule

// ### src/fsc_pkg.sv
// Purpose: constants and types for the flash command sequencer host
// Assumes: word-mode command addresses unless byte mode is selected
// Notes:
// Contract
// - Suspend code B0 at any address pauses a running sector erase.
// - Resume is one write of 30; repeats ignored; suspend allowed again.
// - One F0 write returns to read, or suspended-read if suspended.
// - Unlock is 555/AA then 2AA/55 word, AAA then 555 byte.
// - Program is unlock pair, A0 at first unlock address, then target and data.
// - Bypass entry is unlock pair plus 20; bypass program is A0 then target.
// - Bypass exit is 90 then 00 at any addresses.
// - Sector erase is unlock, 80, unlock, 30 at sector address.
// - Identification is unlock plus 90, then read at offset 00, 01, 02, 03.
// - Chip erase is unlock, 80, unlock, then 10 at first unlock address.
package fsc_pkg;

  // ****************************************************************
  // Command codes and addresses
  // ****************************************************************
  localparam logic [7:0]  CMD_UNLOCK1   = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0]  CMD_RESET     = 8'hF0;
  localparam logic [7:0]  CMD_IDENT     = 8'h90;
  localparam logic [7:0]  CMD_ZERO      = 8'h00;
  localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0]  CMD_BYPASS    = 8'h20;
  localparam logic [7:0]  CMD_ERASE_SET = 8'h80;
  localparam logic [7:0]  CMD_CHIP      = 8'h10;
  localparam logic [7:0]  CMD_SECTOR    = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
  localparam logic [7:0]  CMD_RESUME    = 8'h30;
  localparam logic [7:0]  CMD_QUERY     = 8'h98;
  localparam logic [7:0]  CMD_SECURE    = 8'h88;
  localparam logic [21:0] ADR_W_FIRST   = 22'h000555;
  localparam logic [21:0] ADR_W_SECOND  = 22'h0002AA;
  localparam logic [21:0] ADR_B_FIRST   = 22'h000AAA;
  localparam logic [21:0] ADR_B_SECOND  = 22'h000555;
  localparam logic [21:0] ADR_W_QUERY   = 22'h000055;
  localparam logic [21:0] ADR_B_QUERY   = 22'h0000AA;

  // ****************************************************************
  // Software register map
  // ****************************************************************
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_ADDR      = 4'h1;
  localparam logic [3:0]  REG_DATA      = 4'h2;
  localparam logic [3:0]  REG_STATUS    = 4'h3;
  localparam logic [3:0]  REG_RDATA     = 4'h4;
  localparam int          CTRL_OP_LSB   = 0;
  localparam int          CTRL_BYTE_BIT = 8;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_SUSP_BIT = 1;
  localparam int          STAT_BYP_BIT  = 2;

  // ****************************************************************
  // Timing (MCLK 25 MHz)
  // ****************************************************************
  localparam int          CLK_MHZ       = 25;
  localparam int          T_WP_NS       = 80;
  localparam int          T_WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_SUSP_US     = 20;
  localparam int          T_SUSP_CYC    = T_SUSP_US * CLK_MHZ;
  localparam int          T_WIN_US      = 50;
  localparam int          T_WIN_CYC     = T_WIN_US * CLK_MHZ;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0]
  {
    OP_RESET, OP_IDENT, OP_READ, OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROG,
    OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SUSPEND, OP_RESUME,
    OP_QUERY, OP_SEC_ENTER, OP_SEC_EXIT, OP_SECT_MORE
  } fsc_op_t;

  typedef struct packed
  {
    logic [21:0] addr;
    logic [15:0] data;
  } fsc_cyc_t;

endpackage
